/* File: rtl/pesc_regs.vh */
`ifndef PESC_REGS_VH
`define PESC_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------------------
`define PESC_IDX_EGRESS_RATE    14'h050A
`define PESC_IDX_CABLE_DIAG     14'h0510
`define PESC_IDX_CABLE_TEST     14'h0530
`define PESC_IDX_SPECIAL_CTRL   14'h0531
`define PESC_IDX_INT_STATUS     14'h0540
`define PESC_IDX_INT_MASK       14'h0541
`define PESC_IDX_PORT_CTRL      14'h0542

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PESC_RATE_W             4
`define PESC_DIAG_SHORT10       15
`define PESC_DIAG_RES_HI        14
`define PESC_DIAG_RES_LO        13
`define PESC_DIAG_RUN           12
`define PESC_DIAG_FORCE         11
`define PESC_DIAG_PSAVE_OFF     10
`define PESC_DIAG_LOOP          9
`define PESC_DIAG_FAULT_HI      8
`define PESC_TEST_RUN           15
`define PESC_TEST_RES_HI        14
`define PESC_TEST_RES_LO        13
`define PESC_TEST_SHORT10       12
`define PESC_SPC_FORCE          12
`define PESC_SPC_PSAVE_OFF      11
`define PESC_SPC_LOOP           10
`define PESC_SPC_FAULT_HI       8
`define PESC_CTRL_MULTIQ        0
`define PESC_EV_TEST_DONE       0
`define PESC_EV_CABLE_FAULT     1
`define PESC_EV_W               2

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define PESC_RATE_RST           16'h0000
`define PESC_RATE_UNLIMITED     4'h0
`define PESC_RATE_ABOVE_10M     4'h9
`define PESC_PSAVE_OFF_RST      1'b1
`define PESC_MULTIQ_RST         1'b1
`define PESC_RES_NORMAL         2'b00
`define PESC_CLK_KHZ            125000

`endif

/* File: rtl/pesc_shaper.v */
`timescale 1ns/1ns
`include "pesc_regs.vh"

module pesc_shaper #(
  parameter CLK_KHZ = `PESC_CLK_KHZ,
  parameter CW      = 25
) (
  input  wire                    pclk,       // Core clock
  input  wire                    presetn,    // Async reset, active low
  input  wire [`PESC_RATE_W-1:0] rate_code,  // Effective rate code
  input  wire                    byte_sent,  // One byte left this queue
  output reg                     tx_allow_q  // Queue may send
);

  localparam integer       COST_I = 8 * CLK_KHZ;
  localparam signed [CW:0] COST   = COST_I[CW:0];
  localparam signed [CW:0] CMAX   = {COST[CW-1:0], 1'b0};

  reg        [16:0]   rate_kbps;
  reg signed [CW-1:0] credit_q;
  reg signed [CW-1:0] credit_d;
  reg signed [CW:0]   sum;

  // --------------------------------------------------------------------------
  // Rate table in kbit/s
  // --------------------------------------------------------------------------
  always @* begin
    case (rate_code)
      4'h1:    rate_kbps = 17'd64;
      4'h2:    rate_kbps = 17'd128;
      4'h3:    rate_kbps = 17'd256;
      4'h4:    rate_kbps = 17'd512;
      4'h5:    rate_kbps = 17'd1000;
      4'h6:    rate_kbps = 17'd2000;
      4'h7:    rate_kbps = 17'd4000;
      4'h8:    rate_kbps = 17'd8000;
      4'h9:    rate_kbps = 17'd16000;
      4'hA:    rate_kbps = 17'd32000;
      4'hB:    rate_kbps = 17'd48000;
      4'hC:    rate_kbps = 17'd64000;
      4'hD:    rate_kbps = 17'd72000;
      4'hE:    rate_kbps = 17'd80000;
      4'hF:    rate_kbps = 17'd88000;
      default: rate_kbps = 17'd0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Token bucket: earn rate each cycle, pay 8*clk_khz per byte
  // --------------------------------------------------------------------------
  always @* begin
    sum      = {credit_q[CW-1], credit_q} + $signed({{(CW-16){1'b0}}, rate_kbps});
    if (byte_sent)
      sum = sum - COST;
    if (sum > CMAX)
      sum = CMAX;
    if (sum < -CMAX)
      sum = -CMAX;
    credit_d = sum[CW-1:0];
    if (rate_code == `PESC_RATE_UNLIMITED)
      credit_d = CMAX[CW-1:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      credit_q   <= {CW{1'b0}};
      tx_allow_q <= 1'b1;
    end else begin
      credit_q   <= credit_d;
      tx_allow_q <= (rate_code == `PESC_RATE_UNLIMITED) || !credit_d[CW-1];
    end
  end

endmodule // pesc_shaper

/* File: rtl/pesc_port_regs.v */
`timescale 1ns/1ns
`include "pesc_regs.vh"

module pesc_port_regs #(
  parameter NQ      = 4,
  parameter CLK_KHZ = `PESC_CLK_KHZ
) (
  input  wire          pclk,             // Core clock, 125 MHz
  input  wire          presetn,          // Async reset, active low
  input  wire          psel,             // APB select
  input  wire          penable,          // APB enable
  input  wire          pwrite,           // APB write
  input  wire [15:0]   paddr,            // APB byte address
  input  wire [31:0]   pwdata,           // APB write data
  output reg  [31:0]   prdata,           // APB read data
  output reg           pready,           // APB ready
  output reg           pslverr,          // APB error, unmapped address
  output reg           irq,              // Level interrupt
  input  wire          phy_speed_100,    // PHY link speed is 100 Mbit/s
  input  wire          phy_test_done,    // PHY cable test done level
  input  wire          phy_short10,      // PHY short under ten metres
  input  wire [1:0]    phy_result,       // PHY cable test result
  input  wire [8:0]    phy_fault_count,  // PHY fault distance count
  output reg           phy_test_start,   // Cable test start pulse
  output reg           phy_force_link,   // Force link pass pulse
  output reg           phy_psave_off,    // Power saving disabled
  output reg           phy_remote_loop,  // PMD/PMA loopback
  input  wire [NQ-1:0] q_byte_sent,      // Scheduler sent a byte per queue
  output wire [NQ-1:0] q_tx_allow        // Queue may send, per queue
);

  localparam SW = 14;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [15:0]           rate_q;
  reg                   multiq_q;
  reg                   run_q;
  reg                   short10_q;
  reg  [1:0]            result_q;
  reg  [8:0]            fault_q;
  reg  [`PESC_EV_W-1:0] sts_q;
  reg  [`PESC_EV_W-1:0] mask_q;
  reg  [SW-1:0]         sync1_q;
  reg  [SW-1:0]         sync2_q;
  reg                   done_d1_q;
  reg  [31:0]           rdata_d;
  reg                   hit_d;
  reg  [`PESC_EV_W-1:0] sts_d;
  reg  [NQ*`PESC_RATE_W-1:0] eff_rate;
  reg  [NQ*`PESC_RATE_W-1:0] eff_rate_q;
  reg  [`PESC_EV_W-1:0] sts_seen_q;
  reg  [`PESC_RATE_W-1:0]    code;

  wire                  s_speed_100;
  wire                  s_done;
  wire                  s_short10;
  wire [1:0]            s_result;
  wire [8:0]            s_fault;
  wire                  done_rise;
  wire                  setup;
  wire                  access;
  wire                  wr;
  wire                  rd;
  wire [13:0]           widx;
  wire                  start_req;
  wire                  force_req;
  wire                  wr_mask;
  wire [`PESC_EV_W-1:0] mask_d;

  integer               i;

  // --------------------------------------------------------------------------
  // PHY input synchroniser
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q   <= {SW{1'b0}};
      sync2_q   <= {SW{1'b0}};
      done_d1_q <= 1'b0;
    end else begin
      sync1_q   <= {phy_speed_100, phy_test_done, phy_short10, phy_result, phy_fault_count};
      sync2_q   <= sync1_q;
      done_d1_q <= s_done;
    end
  end

  // Result bundle is only taken on the done edge, after it has settled
  assign s_speed_100 = sync2_q[13];
  assign s_done      = sync2_q[12];
  assign s_short10   = sync2_q[11];
  assign s_result    = sync2_q[10:9];
  assign s_fault     = sync2_q[8:0];
  // Gated by run so a done edge while idle cannot disturb the results
  assign done_rise   = s_done && !done_d1_q && run_q;

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wr     = access && pwrite && !pslverr;
  assign rd     = access && !pwrite && !pslverr;
  assign widx   = paddr[15:2];

  assign start_req = wr && (widx == `PESC_IDX_CABLE_TEST) && pwdata[`PESC_TEST_RUN];
  assign force_req = wr && (((widx == `PESC_IDX_CABLE_DIAG) && pwdata[`PESC_DIAG_FORCE]) ||
                            ((widx == `PESC_IDX_SPECIAL_CTRL) && pwdata[`PESC_SPC_FORCE]));
  assign wr_mask   = wr && (widx == `PESC_IDX_INT_MASK);
  // Mask applies in the cycle it is written, so irq never lags a mask write
  assign mask_d    = wr_mask ? pwdata[`PESC_EV_W-1:0] : mask_q;

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always @* begin
    rdata_d = 32'h0000_0000;
    // Misaligned offsets never hit, whatever the index
    hit_d   = (paddr[1:0] == 2'b00);
    case (widx)
      `PESC_IDX_EGRESS_RATE: begin
        rdata_d[15:0] = rate_q;
      end
      `PESC_IDX_CABLE_DIAG: begin
        rdata_d[`PESC_DIAG_SHORT10]                     = short10_q;
        rdata_d[`PESC_DIAG_RES_HI:`PESC_DIAG_RES_LO]    = result_q;
        rdata_d[`PESC_DIAG_RUN]                         = run_q;
        rdata_d[`PESC_DIAG_FORCE]                       = phy_force_link;
        rdata_d[`PESC_DIAG_PSAVE_OFF]                   = phy_psave_off;
        rdata_d[`PESC_DIAG_LOOP]                        = phy_remote_loop;
        rdata_d[`PESC_DIAG_FAULT_HI:0]                  = fault_q;
      end
      `PESC_IDX_CABLE_TEST: begin
        rdata_d[`PESC_TEST_RUN]                         = run_q;
        rdata_d[`PESC_TEST_RES_HI:`PESC_TEST_RES_LO]    = result_q;
        rdata_d[`PESC_TEST_SHORT10]                     = short10_q;
      end
      `PESC_IDX_SPECIAL_CTRL: begin
        rdata_d[`PESC_SPC_FORCE]                        = phy_force_link;
        rdata_d[`PESC_SPC_PSAVE_OFF]                    = phy_psave_off;
        rdata_d[`PESC_SPC_LOOP]                         = phy_remote_loop;
        rdata_d[`PESC_SPC_FAULT_HI:0]                   = fault_q;
      end
      `PESC_IDX_INT_STATUS: begin
        rdata_d[`PESC_EV_W-1:0] = sts_q;
      end
      `PESC_IDX_INT_MASK: begin
        rdata_d[`PESC_EV_W-1:0] = mask_q;
      end
      `PESC_IDX_PORT_CTRL: begin
        rdata_d[`PESC_CTRL_MULTIQ] = multiq_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // APB answer: zero wait states, registered
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit_d;
      if (setup && !pwrite)
        prdata <= hit_d ? rdata_d : 32'h0000_0000;
      else if (access)
        prdata <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Software-written controls
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q          <= `PESC_RATE_RST;
      multiq_q        <= `PESC_MULTIQ_RST;
      mask_q          <= {`PESC_EV_W{1'b0}};
      phy_psave_off   <= `PESC_PSAVE_OFF_RST;
      phy_remote_loop <= 1'b0;
      phy_force_link  <= 1'b0;
    end else begin
      // One-cycle pulse, so the force bit reads back as one only once
      phy_force_link <= force_req;
      if (wr) begin
        case (widx)
          `PESC_IDX_EGRESS_RATE: begin
            rate_q <= pwdata[15:0];
          end
          `PESC_IDX_CABLE_DIAG: begin
            phy_psave_off   <= pwdata[`PESC_DIAG_PSAVE_OFF];
            phy_remote_loop <= pwdata[`PESC_DIAG_LOOP];
          end
          `PESC_IDX_SPECIAL_CTRL: begin
            phy_psave_off   <= pwdata[`PESC_SPC_PSAVE_OFF];
            phy_remote_loop <= pwdata[`PESC_SPC_LOOP];
          end
          `PESC_IDX_INT_MASK: begin
            mask_q <= pwdata[`PESC_EV_W-1:0];
          end
          `PESC_IDX_PORT_CTRL: begin
            multiq_q <= pwdata[`PESC_CTRL_MULTIQ];
          end
          default: begin
            mask_q <= mask_q;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Cable test sequencing and captured results
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q          <= 1'b0;
      short10_q      <= 1'b0;
      result_q       <= `PESC_RES_NORMAL;
      fault_q        <= 9'h000;
      phy_test_start <= 1'b0;
    end else begin
      // A start while a test runs is dropped: one pulse per test
      phy_test_start <= start_req && !run_q;
      if (start_req && !run_q)
        run_q <= 1'b1;
      else if (done_rise)
        run_q <= 1'b0;
      if (done_rise) begin
        short10_q <= s_short10;
        result_q  <= s_result;
        fault_q   <= s_fault;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status: set wins over read-clear
  // --------------------------------------------------------------------------
  // Only bits already shown in the read data are cleared; an event landing
  // between setup and access stays pending for the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_seen_q <= {`PESC_EV_W{1'b0}};
    end else if (setup && !pwrite && (widx == `PESC_IDX_INT_STATUS)) begin
      sts_seen_q <= sts_q;
    end
  end

  always @* begin
    sts_d = sts_q;
    if (rd && (widx == `PESC_IDX_INT_STATUS))
      sts_d = sts_q & ~sts_seen_q;
    if (done_rise) begin
      sts_d[`PESC_EV_TEST_DONE] = 1'b1;
      if (s_result != `PESC_RES_NORMAL)
        sts_d[`PESC_EV_CABLE_FAULT] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= {`PESC_EV_W{1'b0}};
      irq   <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq   <= |(sts_d & mask_d);
    end
  end

  // --------------------------------------------------------------------------
  // Effective rate code per queue
  // --------------------------------------------------------------------------
  always @* begin
    eff_rate = {NQ*`PESC_RATE_W{1'b0}};
    code     = `PESC_RATE_UNLIMITED;
    for (i = 0; i < NQ; i = i + 1) begin
      code = rate_q[i*`PESC_RATE_W +: `PESC_RATE_W];
      if (!s_speed_100 && (code >= `PESC_RATE_ABOVE_10M))
        code = `PESC_RATE_UNLIMITED;
      if (!multiq_q && (i != 0))
        code = `PESC_RATE_UNLIMITED;
      eff_rate[i*`PESC_RATE_W +: `PESC_RATE_W] = code;
    end
  end

  // --------------------------------------------------------------------------
  // Effective codes registered: cuts the path from the synchroniser and
  // the rate register into the shaper adders
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_rate_q <= {NQ*`PESC_RATE_W{1'b0}};
    end else begin
      eff_rate_q <= eff_rate;
    end
  end

  // --------------------------------------------------------------------------
  // Per-queue shapers
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NQ; g = g + 1) begin : g_q
      pesc_shaper #(
        .CLK_KHZ (CLK_KHZ)
      ) u_shaper (
        .pclk       (pclk),
        .presetn    (presetn),
        .rate_code  (eff_rate_q[g*`PESC_RATE_W +: `PESC_RATE_W]),
        .byte_sent  (q_byte_sent[g]),
        .tx_allow_q (q_tx_allow[g])
      );
    end
  endgenerate

endmodule // pesc_port_regs

/* File: verif/pesc_port_regs_chk.sv */
`timescale 1ns/1ns
`include "pesc_regs.vh"

module pesc_port_regs_chk #(
  parameter NQ      = 4,
  parameter CLK_KHZ = `PESC_CLK_KHZ
) (
  input wire          pclk,            // Core clock
  input wire          presetn,         // Async reset, active low
  input wire          psel,            // APB select
  input wire          penable,         // APB enable
  input wire          pwrite,          // APB write
  input wire [15:0]   paddr,           // APB address
  input wire [31:0]   pwdata,          // APB write data
  input wire [31:0]   prdata,          // APB read data
  input wire          pready,          // APB ready
  input wire          pslverr,         // APB error
  input wire          phy_test_start,  // Test start pulse
  input wire          phy_force_link,  // Force link pulse
  input wire          phy_psave_off,   // Power saving off
  input wire          phy_remote_loop, // Loopback
  input wire [NQ-1:0] q_tx_allow       // Queue may send
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire acc     = psel && penable && pready;
  wire wr_diag = acc && pwrite && paddr == {`PESC_IDX_CABLE_DIAG, 2'b00};
  reg  wr_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_q <= 1'b0;
    else wr_q <= acc && pwrite;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_psave_reset: assert property ($rose(presetn) |-> phy_psave_off)
    else $error("power saving not disabled after reset");
  chk_queues_reset: assert property ($rose(presetn) |-> &q_tx_allow)
    else $error("queue blocked after reset");
  chk_force_pulse: assert property (phy_force_link |=> !phy_force_link)
    else $error("force link did not self clear");
  chk_force_cause: assert property (phy_force_link |-> wr_q)
    else $error("force link without a write");
  chk_start_pulse: assert property (phy_test_start |=> !phy_test_start)
    else $error("test start longer than one cycle");
  chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_unmapped_err: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access without error");
  chk_psave_write: assert property (wr_diag |=> phy_psave_off == $past(pwdata[10]))
    else $error("power saving bit not applied");
  chk_loop_write: assert property (wr_diag |=> phy_remote_loop == $past(pwdata[9]))
    else $error("loopback bit not applied");
  chk_loop_hold: assert property (!(psel && penable && pwrite) |=> $stable(phy_remote_loop))
    else $error("loopback changed without a write");
endmodule // pesc_port_regs_chk

bind pesc_port_regs pesc_port_regs_chk #(.NQ(NQ), .CLK_KHZ(CLK_KHZ)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phy_test_start(phy_test_start), .phy_force_link(phy_force_link),
  .phy_psave_off(phy_psave_off), .phy_remote_loop(phy_remote_loop),
  .q_tx_allow(q_tx_allow));

/* File: verif/pesc_port_regs_tb_top.sv */
`timescale 1ns/1ns
`include "pesc_regs.vh"

module pesc_port_regs_tb_top;
  localparam [15:0] A_RATE = {`PESC_IDX_EGRESS_RATE, 2'b00};
  localparam [15:0] A_DIAG = {`PESC_IDX_CABLE_DIAG, 2'b00};
  localparam [15:0] A_TEST = {`PESC_IDX_CABLE_TEST, 2'b00};
  localparam [15:0] A_SPC  = {`PESC_IDX_SPECIAL_CTRL, 2'b00};
  localparam [15:0] A_STAT = {`PESC_IDX_INT_STATUS, 2'b00};
  localparam [15:0] A_MASK = {`PESC_IDX_INT_MASK, 2'b00};
  localparam [15:0] A_CTRL = {`PESC_IDX_PORT_CTRL, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [15:0] paddr, rv;
  logic [31:0] pwdata, prdata;
  logic        phy_speed_100, phy_test_done, phy_short10, phy_test_start;
  logic        phy_force_link, phy_psave_off, phy_remote_loop;
  logic [1:0]  phy_result;
  logic [8:0]  phy_fault_count;
  logic [3:0]  q_byte_sent, q_tx_allow;
  logic [32:0] exp_q[$];
  int          fail_count, compares, cyc, n, n_start, n_force;

  pesc_port_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .phy_speed_100(phy_speed_100), .phy_test_done(phy_test_done),
    .phy_short10(phy_short10), .phy_result(phy_result), .phy_fault_count(phy_fault_count),
    .phy_test_start(phy_test_start), .phy_force_link(phy_force_link),
    .phy_psave_off(phy_psave_off), .phy_remote_loop(phy_remote_loop),
    .q_byte_sent(q_byte_sent), .q_tx_allow(q_tx_allow));

  // ----------------------------------------------------------------
  // Clock, timeout, read monitor
  // ----------------------------------------------------------------
  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (phy_test_start === 1'b1) n_start++;
    if (phy_force_link === 1'b1) n_force++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 33'h1FFFFFFFF);
    end
  end

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back({17'h0, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic burst(input logic [3:0] e);
    q_byte_sent <= 4'hF;
    repeat (8) @(posedge pclk);
    q_byte_sent <= 4'h0;
    repeat (4) @(posedge pclk);
    check({29'h0, q_tx_allow}, {29'h0, e});
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {phy_speed_100, phy_test_done, phy_short10, phy_result, phy_fault_count} = '0;
    q_byte_sent = 4'h0;
    void'($urandom(32'h87E6));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_RATE, `PESC_RATE_RST);
    rd(A_DIAG, 16'h0400);
    check({32'h0, phy_psave_off}, 33'h1);
    $display("test reset done");
    rv = 16'($urandom);
    apb(1'b1, A_RATE, {16'h0, rv});
    rd(A_RATE, rv);
    apb(1'b1, A_DIAG, 32'hFFFFFFFF);
    check({32'h0, phy_remote_loop}, 33'h1);
    rd(A_DIAG, 16'h0600);
    check(33'(n_force), 33'h1);
    rd(A_SPC, 16'h0C00);
    apb(1'b1, A_SPC, 32'h00000800);
    rd(A_DIAG, 16'h0400);
    apb(1'b1, A_DIAG, 32'h00000200);
    check({31'h0, phy_psave_off, phy_remote_loop}, 33'h1);
    rd(A_SPC, 16'h0400);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, A_RATE + 16'h0001, 32'h0);
    $display("test control fields done");
    apb(1'b1, A_MASK, 32'h3);
    apb(1'b1, A_TEST, 32'h8000);
    rd(A_DIAG, 16'h1200);
    rd(A_TEST, 16'h8000);
    apb(1'b1, A_TEST, 32'h8000);
    check(33'(n_start), 33'h1);
    phy_short10 <= 1'b1;
    phy_result <= 2'b10;
    phy_fault_count <= 9'h1A5;
    @(posedge pclk);
    phy_test_done <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check({32'h0, irq}, 33'h1);
    rd(A_DIAG, 16'hC3A5);
    rd(A_SPC, 16'h05A5);
    rd(A_TEST, 16'h5000);
    rd(A_STAT, 16'h0003);
    @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    rd(A_STAT, 16'h0000);
    phy_test_done <= 1'b0;
    $display("test cable diag done");
    apb(1'b1, A_RATE, 32'h0891);
    burst(4'b1010);
    apb(1'b1, A_CTRL, 32'h0);
    burst(4'b1110);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_RATE, 32'hFFFF);
    phy_speed_100 <= 1'b1;
    repeat (60) @(posedge pclk);
    check({29'h0, q_tx_allow}, 33'hF);
    $display("test shaper done");
    end_sim();
  end
endmodule // pesc_port_regs_tb_top
